//--- logic/bel_consts.svh
`ifndef BEL_CONSTS_SVH
`define BEL_CONSTS_SVH
// Behaviour
// - bus error code in 15:0: prefix 00001, participation, timeout, request, io, level
// - bit 16 is one on address parity error, else zero
// - bit 17 is set on a hard failure indication in a response
// - bit 18 is set on a parity error in a response
// - bit 19 is set on data parity error, controller or bus access
// - bit 20 flags write-back controller access on matching part only
// - bits 21, 22, 23 flag strobe tracker, strobe and address glitches
// - cache error code in 15:0: prefix 00000001, request, type, level
// - bit 63 is set on every log; only software or reset clears it
// - logging while valid sets overflow; valid uncorrected never overwritten

// ==========================================================
// status register field positions
`define BEL_CODE_MSB 15
`define BEL_MS_LSB 16
`define BEL_MS_MSB 23
`define BEL_RSV_LSB 24
`define BEL_RSV_MSB 56
`define BEL_PCC_BIT 57
`define BEL_ADDRV_BIT 58
`define BEL_MISCV_BIT 59
`define BEL_EN_BIT 60
`define BEL_UC_BIT 61
`define BEL_OVER_BIT 62
`define BEL_ENTRY_VALID_BIT 63

// ==========================================================
// model-specific bit positions inside bits 23:16
`define BEL_MS_ADDR_PAR 0
`define BEL_MS_RESP_FAIL 1
`define BEL_MS_RESP_PAR 2
`define BEL_MS_DATA_PAR 3
`define BEL_MS_BAD_ICS 4
`define BEL_MS_PAD_SM 5
`define BEL_MS_STROBE 6
`define BEL_MS_ADDR_GL 7

// ==========================================================
// code prefixes and reset value
`define BEL_BUS_PREFIX 5'h01
`define BEL_CACHE_PREFIX 8'h01
`define BEL_STATUS_RESET 64'h0000_0000_0000_0000
`define BEL_WRITE_MASK 64'hFE00_0000_00FF_FFFF
`endif

//--- logic/bel_pkg.sv
package bel_pkg;
    // bus error report from the detection logic
    typedef struct packed {
        logic [1:0] participation_field;
        logic timeout;
        logic [3:0] request_field;
        logic [1:0] memory_io_field;
        logic [1:0] hierarchy_level_field;
        logic addr_parity;
        logic resp_hard_fail;
        logic resp_parity;
        logic data_parity;
        logic wb_to_interrupt_controller_space;
        logic pad_sm_unsync;
        logic strobe_glitch;
        logic addr_glitch;
    } bel_bus_err_t;

    // cache hierarchy error report
    typedef struct packed {
        logic [3:0] request_field;
        logic [1:0] transaction_type_field;
        logic [1:0] hierarchy_level_field;
    } bel_cache_err_t;
endpackage

//--- logic/bel_err_if.sv
interface bel_err_if;
    import bel_pkg::*;
    bel_bus_err_t bus;
    bel_cache_err_t cache;
    logic bus_ev;
    logic [15:0] code;
    logic [7:0] model_bits;
    modport src (output bus, cache, bus_ev, input code, model_bits);
    modport enc (input bus, cache, bus_ev, output code, model_bits);
endinterface

//--- logic/bel_code_enc.sv
`include "bel_consts.svh"
module bel_code_enc #(
    parameter logic PART_MATCH = 1'b1
) (
    bel_err_if.enc err
);
    import bel_pkg::*;

    // ==========================================================
    // compound code builders
    function automatic logic [15:0] bus_code(input bel_bus_err_t b);
        bus_code = {`BEL_BUS_PREFIX, b.participation_field, b.timeout,
            b.request_field, b.memory_io_field, b.hierarchy_level_field};
    endfunction

    function automatic logic [15:0] cache_code(input bel_cache_err_t c);
        cache_code = {`BEL_CACHE_PREFIX, c.request_field,
            c.transaction_type_field, c.hierarchy_level_field};
    endfunction

    // bus error wins the code field when both arrive together
    wire [15:0] bus_w = bus_code(err.bus);
    wire [15:0] cache_w = cache_code(err.cache);
    assign err.code = err.bus_ev ? bus_w : cache_w;

    // model-specific bits, only for bus errors
    wire [7:0] ms_w;
    assign ms_w[`BEL_MS_ADDR_PAR] = err.bus.addr_parity;
    assign ms_w[`BEL_MS_RESP_FAIL] = err.bus.resp_hard_fail;
    assign ms_w[`BEL_MS_RESP_PAR] = err.bus.resp_parity;
    assign ms_w[`BEL_MS_DATA_PAR] = err.bus.data_parity;
    assign ms_w[`BEL_MS_BAD_ICS] = PART_MATCH
        & err.bus.wb_to_interrupt_controller_space;
    assign ms_w[`BEL_MS_PAD_SM] = err.bus.pad_sm_unsync;
    assign ms_w[`BEL_MS_STROBE] = err.bus.strobe_glitch;
    assign ms_w[`BEL_MS_ADDR_GL] = err.bus.addr_glitch;
    assign err.model_bits = err.bus_ev ? ms_w : 8'h00;
endmodule

//--- logic/bel_logger.sv
`include "bel_consts.svh"
module bel_logger #(
    // arbitrary value standing for the one part with the extra bit
    parameter logic [31:0] FLAGGED_SIGNATURE = 32'h0000_0A5C,
    // arbitrary value of this part's own signature
    parameter logic [31:0] PART_SIGNATURE = 32'h0000_0A5C
) (
    input wire logic sys_clk_i,
    input wire logic resetn_i,
    input wire logic bus_ev_i,
    input wire bel_pkg::bel_bus_err_t bus_err_i,
    input wire logic cache_ev_i,
    input wire bel_pkg::bel_cache_err_t cache_err_i,
    input wire logic err_uc_i,
    input wire logic err_en_i,
    input wire logic err_pcc_i,
    input wire logic err_addrv_i,
    input wire logic err_miscv_i,
    input wire logic rd_en_i,
    input wire logic wr_en_i,
    input wire logic [63:0] wr_data_i,
    output logic [63:0] rd_data_o,
    output logic rd_valid_o,
    output logic [63:0] status_o,
    output logic logged_o
);
    import bel_pkg::*;

    localparam logic PART_MATCH = (PART_SIGNATURE == FLAGGED_SIGNATURE);

    logic [63:0] status_reg;
    logic [63:0] status_next;
    logic [63:0] rd_data_reg;
    logic rd_valid_reg;
    logic logged_reg;
    logic last_bus_reg;

    // ==========================================================
    // error code encoder
    bel_err_if err ();
    assign err.bus = bus_err_i;
    assign err.cache = cache_err_i;
    assign err.bus_ev = bus_ev_i;

    bel_code_enc #(.PART_MATCH(PART_MATCH)) u_enc (
        .err(err.enc)
    );

    // ==========================================================
    // software write mask, bit 20 stays reserved on other parts
    localparam logic [63:0] ICS_BIT_MASK =
        64'h1 << (`BEL_MS_LSB + `BEL_MS_BAD_ICS);
    wire [63:0] wr_mask_w = PART_MATCH ? `BEL_WRITE_MASK
        : (`BEL_WRITE_MASK & ~ICS_BIT_MASK);

    // software write applies first, so a same-cycle event wins
    wire ev_any = bus_ev_i | cache_ev_i;
    wire [63:0] base_w = wr_en_i ? (wr_data_i & wr_mask_w)
                                 : status_reg;
    wire old_valid_w = base_w[`BEL_ENTRY_VALID_BIT];
    wire old_uc_w = base_w[`BEL_UC_BIT];
    wire old_en_w = base_w[`BEL_EN_BIT];

    // overwrite policy while an entry is valid
    wire overwrite_w = !old_valid_w
        | (!old_uc_w & (err_uc_i | (err_en_i & !old_en_w)));
    wire over_w = old_valid_w | base_w[`BEL_OVER_BIT];

    // fresh entry built from the encoder and the event flags
    wire [63:0] entry_w = {1'b1, over_w, err_uc_i, err_en_i,
        err_miscv_i, err_addrv_i, err_pcc_i, 33'h0,
        err.model_bits, err.code};

    // entry kept, only overflow raised
    wire [63:0] kept_w = base_w | (64'h1 << `BEL_OVER_BIT);

    // ==========================================================
    // next status value
    always_comb begin
        if (!ev_any) begin
            status_next = base_w;
        end else if (overwrite_w) begin
            status_next = entry_w;
        end else begin
            status_next = kept_w;
        end
    end

    // status register, only software or reset clears the valid flag
    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            status_reg <= `BEL_STATUS_RESET;
        end else begin
            status_reg <= status_next;
        end
    end

    // ==========================================================
    // register read port and log indication
    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            rd_data_reg <= 64'h0000_0000_0000_0000;
            rd_valid_reg <= 1'b0;
            logged_reg <= 1'b0;
            last_bus_reg <= 1'b0;
        end else begin
            rd_valid_reg <= rd_en_i;
            if (rd_en_i) begin
                rd_data_reg <= status_reg;
            end
            logged_reg <= ev_any & overwrite_w;
            last_bus_reg <= bus_ev_i;
        end
    end

    assign rd_data_o = rd_data_reg;
    assign rd_valid_o = rd_valid_reg;
    assign status_o = status_reg;
    assign logged_o = logged_reg;

    // ==========================================================
    // checks
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!resetn_i);

    sequence s_busy_uc;
        status_reg[`BEL_ENTRY_VALID_BIT] && status_reg[`BEL_UC_BIT]
        && !wr_en_i;
    endsequence

    sequence s_busy_cor;
        status_reg[`BEL_ENTRY_VALID_BIT] && !status_reg[`BEL_UC_BIT]
        && !wr_en_i;
    endsequence

    sequence s_event;
        ev_any;
    endsequence

    sequence s_bus_write;
        bus_ev_i && overwrite_w;
    endsequence

    a_valid_on_log: assert property (
        s_event |=> status_reg[`BEL_ENTRY_VALID_BIT])
        else $error("valid flag not set after error");

    a_valid_sw_clear: assert property (
        $fell(status_reg[`BEL_ENTRY_VALID_BIT]) |-> $past(wr_en_i))
        else $error("valid flag cleared without software write");

    a_over_when_busy: assert property (
        status_reg[`BEL_ENTRY_VALID_BIT] && !wr_en_i ##0 s_event
        |=> status_reg[`BEL_OVER_BIT])
        else $error("overflow not raised on busy entry");

    a_over_sticky: assert property (
        status_reg[`BEL_OVER_BIT] && !wr_en_i |=> status_reg[`BEL_OVER_BIT])
        else $error("overflow flag lost without software write");

    a_uc_kept: assert property (
        s_busy_uc ##0 s_event |=> $stable(status_reg[23:0])
        && status_reg[`BEL_UC_BIT])
        else $error("valid uncorrected entry overwritten");

    a_uc_over_cor: assert property (
        s_busy_cor ##0 s_event ##0 err_uc_i
        |=> status_reg[`BEL_UC_BIT] && status_reg[`BEL_OVER_BIT])
        else $error("uncorrected error did not replace corrected one");

    a_en_over_dis: assert property (
        s_busy_cor ##0 !status_reg[`BEL_EN_BIT] ##0 s_event ##0 err_en_i
        |=> status_reg[`BEL_EN_BIT] && status_reg[`BEL_OVER_BIT])
        else $error("enabled error did not replace disabled one");

    a_reserved_zero: assert property (
        status_reg[`BEL_RSV_MSB:`BEL_RSV_LSB] == 33'h0)
        else $error("reserved status bits not zero");

    a_write_lands: assert property (
        wr_en_i && !ev_any
        |=> status_reg == ($past(wr_data_i) & wr_mask_w))
        else $error("software write not taken through mask");

    a_hold_quiet: assert property (
        !ev_any && !wr_en_i |=> $stable(status_reg))
        else $error("status changed without event or write");

    a_bus_form: assert property (
        logged_reg && last_bus_reg |-> status_reg[15:11] == `BEL_BUS_PREFIX)
        else $error("bus error code form wrong");

    a_cache_form: assert property (
        logged_reg && !last_bus_reg |-> status_reg[15:8] == `BEL_CACHE_PREFIX
        && status_reg[`BEL_MS_MSB:`BEL_MS_LSB] == 8'h00)
        else $error("cache error code form wrong");

    a_addr_parity: assert property (
        s_bus_write
        |=> status_reg[`BEL_MS_LSB] == $past(bus_err_i.addr_parity))
        else $error("address parity bit does not follow detection");

    a_resp_fail: assert property (
        s_bus_write |=> status_reg[`BEL_MS_LSB + `BEL_MS_RESP_FAIL]
        == $past(bus_err_i.resp_hard_fail))
        else $error("response failure bit does not follow detection");

    a_resp_parity: assert property (
        s_bus_write |=> status_reg[`BEL_MS_LSB + `BEL_MS_RESP_PAR]
        == $past(bus_err_i.resp_parity))
        else $error("response parity bit does not follow detection");

    a_data_parity: assert property (
        s_bus_write |=> status_reg[`BEL_MS_LSB + `BEL_MS_DATA_PAR]
        == $past(bus_err_i.data_parity))
        else $error("data parity bit does not follow detection");

    a_pad_bits: assert property (
        s_bus_write |=> status_reg[`BEL_MS_MSB:`BEL_MS_LSB + `BEL_MS_PAD_SM]
        == $past({bus_err_i.addr_glitch, bus_err_i.strobe_glitch,
        bus_err_i.pad_sm_unsync}))
        else $error("strobe tracker bits do not follow detection");

    a_ics_reserved: assert property (
        !PART_MATCH |-> !status_reg[`BEL_MS_LSB + `BEL_MS_BAD_ICS])
        else $error("controller request bit set on other part");

    a_ics_follows: assert property (
        s_bus_write
        |=> status_reg[`BEL_MS_LSB + `BEL_MS_BAD_ICS] == (PART_MATCH
            && $past(bus_err_i.wb_to_interrupt_controller_space)))
        else $error("controller request bit does not follow detection");

    a_logged_new: assert property (
        s_event ##0 overwrite_w |=> logged_o)
        else $error("new entry without log indication");

    a_logged_once: assert property (
        !ev_any |=> !logged_o)
        else $error("log indication without an error");

    a_read_data: assert property (
        rd_en_i |=> rd_valid_o && rd_data_o == $past(status_reg))
        else $error("read data does not match status");
endmodule

//--- tb/bel_bus_agent.sv
module bel_bus_agent
    import bel_pkg::*;
(
    input wire logic sys_clk_i,
    output logic bus_ev_o,
    output bel_bus_err_t bus_err_o,
    output logic cache_ev_o,
    output bel_cache_err_t cache_err_o,
    output logic [4:0] flags_o
);
    timeunit 1ns;
    timeprecision 100ps;
    // quiet bus at time zero
    initial begin
        bus_ev_o = 1'b0;
        cache_ev_o = 1'b0;
        bus_err_o = '0;
        cache_err_o = '0;
        flags_o = '0;
    end
    // one-cycle report, fields valid only with the strobe
    task automatic fire(input logic is_bus, input logic [18:0] pay,
                        input logic [4:0] fl);
        @(posedge sys_clk_i);
        bus_ev_o <= is_bus;
        cache_ev_o <= !is_bus;
        bus_err_o <= bel_bus_err_t'(pay);
        cache_err_o <= bel_cache_err_t'(pay[7:0]);
        flags_o <= fl;
        @(posedge sys_clk_i);
        bus_ev_o <= 1'b0;
        cache_ev_o <= 1'b0;
        // released fields flip so stale values never look valid
        bus_err_o <= ~bus_err_o;
        cache_err_o <= ~cache_err_o;
        flags_o <= ~flags_o;
    endtask
endmodule

//--- tb/bus_error_status_logger_tb.sv
module bus_error_status_logger_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import bel_pkg::*;
    logic sys_clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic rd_en_i = 1'b0;
    logic wr_en_i = 1'b0;
    logic [63:0] wr_data_i = '0;
    logic [63:0] rd_data_o, status_o, exp;
    logic rd_valid_o, logged_o, bus_ev, cache_ev;
    bel_bus_err_t bus_err;
    bel_cache_err_t cache_err;
    logic [4:0] fl;
    logic [10:0] f11;
    logic [7:0] ms;
    int n_errors = 0;
    int compares = 0;
    // ==========
    // clock and parts
    initial begin
        forever #25 sys_clk_i = ~sys_clk_i;
    end
    bel_bus_agent far_side (.sys_clk_i(sys_clk_i), .bus_ev_o(bus_ev),
        .bus_err_o(bus_err), .cache_ev_o(cache_ev),
        .cache_err_o(cache_err), .flags_o(fl));
    bel_logger dut (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i),
        .bus_ev_i(bus_ev), .bus_err_i(bus_err), .cache_ev_i(cache_ev),
        .cache_err_i(cache_err), .err_uc_i(fl[4]), .err_en_i(fl[3]),
        .err_miscv_i(fl[2]), .err_addrv_i(fl[1]), .err_pcc_i(fl[0]),
        .rd_en_i(rd_en_i), .wr_en_i(wr_en_i), .wr_data_i(wr_data_i),
        .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o),
        .status_o(status_o), .logged_o(logged_o));
    // ==========
    // access tasks
    function automatic logic [7:0] rev(input logic [7:0] v);
        for (int i = 0; i < 8; i++) begin
            rev[i] = v[7 - i];
        end
    endfunction
    task automatic check(input string what, input logic [63:0] e,
                         input logic [63:0] g);
        compares++;
        if (g !== e) begin
            n_errors++;
            $display("Error %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic test_done();
        if (n_errors == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic wr(input logic [63:0] d);
        @(posedge sys_clk_i);
        wr_en_i <= 1'b1;
        wr_data_i <= d;
        @(posedge sys_clk_i);
        wr_en_i <= 1'b0;
        wr_data_i <= ~d;
        #1;
    endtask
    task automatic rd(input logic [63:0] e);
        @(posedge sys_clk_i);
        rd_en_i <= 1'b1;
        @(posedge sys_clk_i);
        rd_en_i <= 1'b0;
        #1;
        check("rd_valid", 64'h1, {63'h0, rd_valid_o});
        check("rd_data", e, rd_data_o);
    endtask
    // ==========
    // sequence
    initial begin
        repeat (6) @(posedge sys_clk_i);
        resetn_i <= 1'b1;
        rd(64'h0);
        // each model bit alone, distinct code fields
        for (int i = 0; i < 8; i++) begin
            ms = 8'h01 << i;
            f11 = 11'h155 + 11'(i * 179);
            wr(64'h0);
            far_side.fire(1'b1, {f11, rev(ms)}, 5'(i + 3));
            #1;
            exp = {2'b10, 5'(i + 3), 33'h0, ms, 5'h01, f11};
            check("bus entry", exp, status_o);
            check("logged", 64'h1, {63'h0, logged_o});
        end
        repeat (3) @(posedge sys_clk_i);
        rd(exp);
        // cache code form
        wr(64'h0);
        far_side.fire(1'b0, {11'h7FF, 8'hA6}, 5'h08);
        #1;
        check("cache", {2'b10, 5'h08, 41'h0, 8'h01, 8'hA6}, status_o);
        // uncorrected replaces corrected, then is kept
        far_side.fire(1'b1, {11'h000, 8'h01}, 5'h18);
        #1;
        exp = {2'b11, 5'h18, 33'h0, 8'h80, 5'h01, 11'h000};
        check("overwrite", exp, status_o);
        far_side.fire(1'b1, {11'h3FF, 8'hFF}, 5'h01);
        #1;
        check("kept", exp, status_o);
        check("kept logged", 64'h0, {63'h0, logged_o});
        // reserved bits stay zero, software clears valid
        wr(64'hFFFF_FFFF_FFFF_FFFF);
        check("reserved", 64'h0, {31'h0, status_o[56:24]});
        check("low", 64'hFFFFFF, {40'h0, status_o[23:0]});
        wr(64'h0);
        repeat (2) @(posedge sys_clk_i);
        #1;
        check("cleared", 64'h0, status_o);
        // enabled entry replaces a disabled one, then is kept
        far_side.fire(1'b1, {11'h2AA, 8'h00}, 5'h00);
        #1;
        exp = {2'b10, 5'h00, 33'h0, 8'h00, 5'h01, 11'h2AA};
        check("disabled", exp, status_o);
        far_side.fire(1'b1, {11'h0F0, rev(8'h04)}, 5'h08);
        #1;
        exp = {2'b11, 5'h08, 33'h0, 8'h04, 5'h01, 11'h0F0};
        check("enabled", exp, status_o);
        far_side.fire(1'b1, {11'h111, 8'hFF}, 5'h00);
        #1;
        check("not replaced", exp, status_o);
        check("not logged", 64'h0, {63'h0, logged_o});
        test_done();
    end
endmodule
